// ==== testbench/mnd_datapath_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module mnd_datapath_bench;
  // ==========================================================
  // Clock, reset and bus signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] resp;
  logic [31:0] rdv;
  int lat;
  int fail_count = 0;
  int num_checks = 0;

  mnd_datapath DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  // Half period of 2 ns gives the 250 MHz core clock
  initial begin
    forever #2 aclk = ~aclk;
  end

  // ==========================================================
  // Comparison and closing
  task automatic chk_data(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s response: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // AXI4-Lite master; address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Latency from the later handshake to the response, kept for timing checks
    lat = 0;
    do begin
      @(posedge aclk);
      lat++;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hf);
    chk_resp("write", mnd_pkg::RESP_OKAY, resp);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    chk_resp(nm, mnd_pkg::RESP_OKAY, resp);
    chk_data(nm, exp, rdv);
  endtask

  task automatic mem_wr(input logic [11:0] ad, input logic [7:0] v);
    wr(mnd_pkg::OFF_MADDR, {20'h00000, ad});
    wr(mnd_pkg::OFF_MDATA, {24'h000000, v});
  endtask

  task automatic mem_chk(input logic [11:0] ad, input logic [7:0] v);
    wr(mnd_pkg::OFF_MADDR, {20'h00000, ad});
    rd_chk("memory byte", mnd_pkg::OFF_MDATA, {24'h000000, v});
  endtask

  // One instruction; the read of CTRL waits out the four quarters
  task automatic exec(input logic [15:0] op, input logic [31:0] ctrl_exp);
    axi_write(mnd_pkg::OFF_INSTR, {16'h0000, op}, 4'hf);
    chk_resp("instr write", mnd_pkg::RESP_OKAY, resp);
    chk_data("instr response latency", 32'h0000_0002, lat);
    // Core sits in Q2 here with b already taken, so only the run itself stalls the bus
    @(posedge aclk);
    chk_data("readies while busy", 32'h0000_0000, {30'h0, awready, arready});
    rd_chk("ctrl", mnd_pkg::OFF_CTRL, ctrl_exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd_chk("w reset", mnd_pkg::OFF_WREG, 32'h0000_0000);
    rd_chk("bank reset", mnd_pkg::OFF_BANK, 32'h0000_0000);
    rd_chk("prod reset", mnd_pkg::OFF_PROD, 32'h0000_0000);
    rd_chk("status reset", mnd_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk("ctrl reset", mnd_pkg::OFF_CTRL, 32'h0000_0000);
    axi_read(8'h20);
    chk_resp("unmapped read", mnd_pkg::RESP_SLVERR, resp);
    chk_data("unmapped read", 32'h0000_0000, rdv);
    axi_read(8'h06);
    chk_resp("misaligned read", mnd_pkg::RESP_SLVERR, resp);
    axi_write(8'h24, 32'h0000_00ff, 4'hf);
    chk_resp("unmapped write", mnd_pkg::RESP_SLVERR, resp);
    wr(mnd_pkg::OFF_PROD, 32'h0000_1234);
    rd_chk("prod read only", mnd_pkg::OFF_PROD, 32'h0000_0000);
    axi_write(mnd_pkg::OFF_WREG, 32'h1234_56ab, 4'h1);
    rd_chk("w byte lane", mnd_pkg::OFF_WREG, 32'h0000_00ab);
    $display("test reset done");
  endtask

  task automatic t_lit();
    wr(mnd_pkg::OFF_STATUS, 32'h0000_0015);
    wr(mnd_pkg::OFF_WREG, 32'h0000_00e2);
    exec(16'h0dc4, 32'h0000_0000);
    rd_chk("literal product", mnd_pkg::OFF_PROD, 32'h0000_ad08);
    rd_chk("w kept", mnd_pkg::OFF_WREG, 32'h0000_00e2);
    wr(mnd_pkg::OFF_WREG, 32'h0000_00ff);
    exec(16'h0dff, 32'h0000_0000);
    rd_chk("largest product", mnd_pkg::OFF_PROD, 32'h0000_fe01);
    wr(mnd_pkg::OFF_WREG, 32'h0000_0000);
    exec(16'h0d55, 32'h0000_0000);
    rd_chk("zero product", mnd_pkg::OFF_PROD, 32'h0000_0000);
    rd_chk("status kept", mnd_pkg::OFF_STATUS, 32'h0000_0015);
    $display("test literal multiply done");
  endtask

  task automatic t_regmul();
    wr(mnd_pkg::OFF_BANK, 32'h0000_0005);
    mem_wr(12'h010, 8'hb5);
    mem_wr(12'h510, 8'h03);
    mem_wr(12'hf90, 8'h02);
    wr(mnd_pkg::OFF_WREG, 32'h0000_00c4);
    exec(16'h0210, 32'h0000_0000);
    rd_chk("access low product", mnd_pkg::OFF_PROD, 32'h0000_8a94);
    mem_chk(12'h010, 8'hb5);
    rd_chk("w kept", mnd_pkg::OFF_WREG, 32'h0000_00c4);
    exec(16'h0310, 32'h0000_0000);
    rd_chk("banked product", mnd_pkg::OFF_PROD, 32'h0000_024c);
    exec(16'h0290, 32'h0000_0000);
    rd_chk("access high product", mnd_pkg::OFF_PROD, 32'h0000_0188);
    rd_chk("status kept", mnd_pkg::OFF_STATUS, 32'h0000_0015);
    $display("test register multiply done");
  endtask

  task automatic t_neg();
    wr(mnd_pkg::OFF_STATUS, 32'h0000_0000);
    mem_wr(12'h020, 8'h3a);
    exec(16'h6c20, 32'h0000_0000);
    mem_chk(12'h020, 8'hc6);
    rd_chk("flags plain", mnd_pkg::OFF_STATUS, 32'h0000_0010);
    mem_wr(12'h530, 8'h00);
    exec(16'h6d30, 32'h0000_0000);
    mem_chk(12'h530, 8'h00);
    rd_chk("flags zero", mnd_pkg::OFF_STATUS, 32'h0000_0007);
    mem_wr(12'hfa0, 8'h80);
    exec(16'h6ca0, 32'h0000_0000);
    mem_chk(12'hfa0, 8'h80);
    rd_chk("flags overflow", mnd_pkg::OFF_STATUS, 32'h0000_001a);
    rd_chk("prod kept", mnd_pkg::OFF_PROD, 32'h0000_0188);
    rd_chk("w kept", mnd_pkg::OFF_WREG, 32'h0000_00c4);
    $display("test negate done");
  endtask

  // An unknown opcode must leave results alone, and the next good one clears the mark
  task automatic t_illegal();
    exec(16'hffff, 32'h0000_0002);
    rd_chk("prod kept", mnd_pkg::OFF_PROD, 32'h0000_0188);
    exec(16'h0d01, 32'h0000_0000);
    rd_chk("product by one", mnd_pkg::OFF_PROD, 32'h0000_00c4);
    $display("test illegal opcode done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_lit();
    t_regmul();
    t_neg();
    t_illegal();
    end_sim();
  end

  // Whole run needs a few hundred cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_sim();
  end
endmodule // mnd_datapath_bench

`default_nettype wire

// ==== verilog/mnd_alu.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Multiplier and negator, purely combinational
module mnd_alu (
  input wire logic [7:0] w_val,
  input wire logic [7:0] operand,
  output var mnd_pkg::mnd_alu_t res
);

  // Full 16-bit product, nothing dropped; negate flags
  always_comb begin
    res.prod = {8'h00, w_val} * {8'h00, operand};
    res.neg = ~operand + 8'h01;
    res.flags.c = (operand == 8'h00);
    res.flags.dc = (operand[3:0] == 4'h0);
    res.flags.ov = (operand == 8'h80);
    res.flags.z = (operand == 8'h00);
    res.flags.n = res.neg[7];
  end

endmodule // mnd_alu

`default_nettype wire

// ==== verilog/mnd_data_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Data memory, one port, registered read (read before write)
module mnd_data_mem (
  input wire logic aclk,
  input wire logic [mnd_pkg::MEM_AW-1:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q
);

  logic [7:0] mem_q [mnd_pkg::MEM_DEPTH];

  // No reset: contents are software's business
  always_ff @(posedge aclk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    rdata_q <= mem_q[addr];
  end

endmodule // mnd_data_mem

`default_nettype wire

// ==== verilog/mnd_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none

module mnd_datapath (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [mnd_pkg::AXI_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [mnd_pkg::AXI_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // ==========================================================
  // State
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d, rd_pend_q, rd_pend_d;
  logic [7:0] rd_addr_q, rd_addr_d;
  logic [31:0] rdata_q, rdata_d;
  mnd_pkg::mnd_state_t st_q, st_d;
  mnd_pkg::mnd_op_t op_q, op_d;
  logic [15:0] instr_q, instr_d, prod_q, prod_d;
  logic [7:0] w_q, w_d, operand_q, operand_d;
  logic [3:0] bsr_q, bsr_d;
  logic [11:0] addr_q, addr_d, maddr_q, maddr_d;
  mnd_pkg::mnd_flags_t flags_q, flags_d;
  mnd_pkg::mnd_alu_t alu_res_q, alu_res_d, alu_out;
  logic illegal_q, illegal_d;
  logic do_write, start, core_port, bus_mem_we;
  logic [31:0] wr_val;
  logic [7:0] alu_b, mem_rdata, mem_wdata;
  logic [11:0] mem_addr;
  logic mem_we;

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ==========================================================
  // Helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= mnd_pkg::OFF_CTRL);
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    apply_strb = v;
  endfunction

  // Register view; reads of the data window return the last memory read
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      mnd_pkg::OFF_INSTR: v[15:0] = instr_q;
      mnd_pkg::OFF_WREG: v[7:0] = w_q;
      mnd_pkg::OFF_BANK: v[3:0] = bsr_q;
      mnd_pkg::OFF_PROD: v[15:0] = prod_q;
      mnd_pkg::OFF_STATUS: v[4:0] = flags_q;
      mnd_pkg::OFF_MADDR: v[11:0] = maddr_q;
      mnd_pkg::OFF_MDATA: v[7:0] = mem_rdata;
      mnd_pkg::OFF_CTRL: begin
        v[mnd_pkg::CTRL_BUSY_BIT] = (st_q != mnd_pkg::ST_IDLE);
        v[mnd_pkg::CTRL_ILLEGAL_BIT] = illegal_q;
      end
      default: v = 32'h0000_0000;
    endcase
    reg_view = v;
  endfunction

  // ==========================================================
  // Submodules
  mnd_alu u_alu (
    .w_val(w_q),
    .operand(alu_b),
    .res(alu_out)
  );

  mnd_data_mem u_mem (
    .aclk(aclk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  // Memory port: the core owns it in Q2 (read) and Q4 (write)
  assign core_port = (st_q == mnd_pkg::ST_Q2) || (st_q == mnd_pkg::ST_Q4);
  assign bus_mem_we = do_write && (awaddr_q == mnd_pkg::OFF_MDATA) && wstrb_q[0];
  assign mem_addr = core_port ? addr_q : maddr_q;
  assign mem_we = ((st_q == mnd_pkg::ST_Q4) && (op_q == mnd_pkg::OP_NEG))
                  || (!core_port && bus_mem_we);
  assign mem_wdata = (st_q == mnd_pkg::ST_Q4) ? alu_res_q.neg : wdata_q[7:0];
  assign alu_b = (op_q == mnd_pkg::OP_MULL) ? instr_q[7:0] : mem_rdata;

  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign start = do_write && (awaddr_q == mnd_pkg::OFF_INSTR);
  // Process, not assign: reg_view reads registers that are not its arguments
  always_comb begin
    wr_val = apply_strb(reg_view(awaddr_q), wdata_q, wstrb_q);
  end

  // ==========================================================
  // Core sequencer: one instruction cycle of four quarters
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    instr_d = instr_q;
    addr_d = addr_q;
    operand_d = operand_q;
    alu_res_d = alu_res_q;
    prod_d = prod_q;
    flags_d = flags_q;
    illegal_d = illegal_q;
    w_d = w_q;
    bsr_d = bsr_q;
    maddr_d = maddr_q;
    // Bus writes only land while idle, since the slave stalls otherwise
    if (do_write) begin
      case (awaddr_q)
        mnd_pkg::OFF_WREG: w_d = wr_val[7:0];
        mnd_pkg::OFF_BANK: bsr_d = wr_val[3:0];
        mnd_pkg::OFF_STATUS: flags_d = wr_val[4:0];
        mnd_pkg::OFF_MADDR: maddr_d = wr_val[11:0];
        default: ;
      endcase
    end
    unique case (st_q)
      mnd_pkg::ST_IDLE: begin
        if (start) begin
          instr_d = wr_val[15:0];
          st_d = mnd_pkg::ST_Q1;
        end
      end
      mnd_pkg::ST_Q1: begin
        // Decode and form the operand address
        if (instr_q[15:8] == mnd_pkg::MULL_HI) begin
          op_d = mnd_pkg::OP_MULL;
        end else if (instr_q[15:9] == mnd_pkg::MULF_HI) begin
          op_d = mnd_pkg::OP_MULF;
        end else if (instr_q[15:9] == mnd_pkg::NEG_HI) begin
          op_d = mnd_pkg::OP_NEG;
        end else begin
          op_d = mnd_pkg::OP_NONE;
        end
        illegal_d = (op_d == mnd_pkg::OP_NONE);
        if (instr_q[mnd_pkg::BANK_ACCESS_BIT]) begin
          addr_d = {bsr_q, instr_q[7:0]};
        end else if (instr_q[mnd_pkg::ACCESS_SPLIT_BIT]) begin
          addr_d = {mnd_pkg::ACCESS_HI_BANK, instr_q[7:0]};
        end else begin
          addr_d = {mnd_pkg::ACCESS_LO_BANK, instr_q[7:0]};
        end
        st_d = mnd_pkg::ST_Q2;
      end
      mnd_pkg::ST_Q2: begin
        st_d = mnd_pkg::ST_Q3; // Memory read issued on the port this quarter
      end
      mnd_pkg::ST_Q3: begin
        operand_d = alu_b;
        alu_res_d = alu_out;
        st_d = mnd_pkg::ST_Q4;
      end
      mnd_pkg::ST_Q4: begin
        // Results land only in the last quarter; W is never written here
        if (op_q == mnd_pkg::OP_MULL || op_q == mnd_pkg::OP_MULF) begin
          prod_d = alu_res_q.prod;
        end
        if (op_q == mnd_pkg::OP_NEG) begin
          flags_d = alu_res_q.flags;
        end
        st_d = mnd_pkg::ST_IDLE;
      end
      default: st_d = mnd_pkg::ST_IDLE;
    endcase
  end

  // Core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= mnd_pkg::ST_IDLE;
      op_q <= mnd_pkg::OP_NONE;
      instr_q <= mnd_pkg::INSTR_RST;
      addr_q <= 12'h000;
      operand_q <= 8'h00;
      alu_res_q <= '0;
      prod_q <= mnd_pkg::PROD_RST;
      flags_q <= mnd_pkg::FLAGS_RST;
      illegal_q <= 1'b0;
      w_q <= mnd_pkg::W_RST;
      bsr_q <= mnd_pkg::BANK_RST;
      maddr_q <= mnd_pkg::MADDR_RST;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      instr_q <= instr_d;
      addr_q <= addr_d;
      operand_q <= operand_d;
      alu_res_q <= alu_res_d;
      prod_q <= prod_d;
      flags_q <= flags_d;
      illegal_q <= illegal_d;
      w_q <= w_d;
      bsr_q <= bsr_d;
      maddr_q <= maddr_d;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel; stalls while an instruction runs
  always_comb begin
    aw_have_d = aw_have_q;
    awaddr_d = awaddr_q;
    w_have_d = w_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(awaddr_q) ? mnd_pkg::RESP_OKAY : mnd_pkg::RESP_SLVERR;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d && (st_d == mnd_pkg::ST_IDLE);
    wready_d = !w_have_d && !bvalid_d && (st_d == mnd_pkg::ST_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= mnd_pkg::RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      awaddr_q <= awaddr_d;
      w_have_q <= w_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel; one wait cycle covers the memory latency
  always_comb begin
    rd_pend_d = rd_pend_q;
    rd_addr_d = rd_addr_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && arready_q) begin
      rd_pend_d = 1'b1;
      rd_addr_d = araddr;
    end
    if (rd_pend_q) begin
      rd_pend_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = reg_view(rd_addr_q);
      rresp_d = is_mapped(rd_addr_q) ? mnd_pkg::RESP_OKAY : mnd_pkg::RESP_SLVERR;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rd_pend_d && !rvalid_d && (st_d == mnd_pkg::ST_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= mnd_pkg::RESP_OKAY;
      arready_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arready_q <= arready_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_quarters;
    st_q == mnd_pkg::ST_Q1 ##1 st_q == mnd_pkg::ST_Q2 ##1 st_q == mnd_pkg::ST_Q3
    ##1 st_q == mnd_pkg::ST_Q4 ##1 st_q == mnd_pkg::ST_IDLE;
  endsequence

  sequence s_neg_written;
    mem_we && (mem_addr == addr_q) && (mem_wdata == 8'(8'h00 - operand_q));
  endsequence

  // Flags of 0 - f, worked out from the operand alone
  sequence s_neg_flags;
    flags_q.z == (operand_q == 8'h00) && flags_q.c == (operand_q == 8'h00)
    && flags_q.dc == (operand_q[3:0] == 4'h0) && flags_q.ov == (operand_q == 8'h80)
    && flags_q.n == ((operand_q != 8'h00 && operand_q != 8'h80) ? !operand_q[7] : operand_q[7]);
  endsequence

  property p_one_cycle;
    (st_q == mnd_pkg::ST_IDLE && start) |=> s_quarters;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction not four quarters");

  property p_mull_prod;
    (st_q == mnd_pkg::ST_Q4 && op_q == mnd_pkg::OP_MULL)
      |=> (prod_q == {8'h00, w_q} * {8'h00, instr_q[7:0]});
  endproperty
  a_mull_prod: assert property (p_mull_prod) else $error("literal product wrong");

  property p_mulf_prod;
    (st_q == mnd_pkg::ST_Q4 && op_q == mnd_pkg::OP_MULF)
      |=> (prod_q == {8'h00, w_q} * {8'h00, operand_q});
  endproperty
  a_mulf_prod: assert property (p_mulf_prod) else $error("register product wrong");

  property p_w_kept;
    (st_q == mnd_pkg::ST_Q1) |-> ##4 (w_q == $past(w_q, 4));
  endproperty
  a_w_kept: assert property (p_w_kept) else $error("W changed by instruction");

  property p_mul_mem_kept;
    (st_q == mnd_pkg::ST_Q4 && op_q != mnd_pkg::OP_NEG) |-> !mem_we;
  endproperty
  a_mul_mem_kept: assert property (p_mul_mem_kept) else $error("multiply wrote memory");

  property p_mul_flags;
    (st_q == mnd_pkg::ST_Q1 && instr_q[15:9] != mnd_pkg::NEG_HI) |-> ##4 $stable(flags_q);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("flags moved by multiply");

  property p_bank_sel;
    (st_q == mnd_pkg::ST_Q2 && instr_q[mnd_pkg::BANK_ACCESS_BIT]) |-> (addr_q[11:8] == bsr_q);
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank select not used");

  property p_access;
    (st_q == mnd_pkg::ST_Q2 && !instr_q[mnd_pkg::BANK_ACCESS_BIT])
      |-> (addr_q[11:8] == (instr_q[7] ? mnd_pkg::ACCESS_HI_BANK : mnd_pkg::ACCESS_LO_BANK));
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_neg_write;
    (st_q == mnd_pkg::ST_Q3 && op_q == mnd_pkg::OP_NEG) |=> s_neg_written ##1 s_neg_flags;
  endproperty
  a_neg_write: assert property (p_neg_write) else $error("negate result or flags wrong");

endmodule // mnd_datapath

`default_nettype wire

// ==== verilog/mnd_pkg.sv ====
package mnd_pkg;

  // ==========================================================
  // Register map, byte addresses on the AXI4-Lite slave
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WREG = 8'h04;
  localparam logic [7:0] OFF_BANK = 8'h08;
  localparam logic [7:0] OFF_PROD = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MADDR = 8'h14;
  localparam logic [7:0] OFF_MDATA = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_BUSY_BIT = 0;
  localparam int unsigned CTRL_ILLEGAL_BIT = 1;
  localparam int unsigned BANK_ACCESS_BIT = 8;
  localparam int unsigned ACCESS_SPLIT_BIT = 7;

  // ==========================================================
  // Opcode upper bits and access bank layout
  localparam logic [7:0] MULL_HI = 8'h0d;
  localparam logic [6:0] MULF_HI = 7'h01;
  localparam logic [6:0] NEG_HI = 7'h36;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // ==========================================================
  // Sizes and reset values
  localparam int unsigned MEM_AW = 12;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [15:0] PROD_RST = 16'h0000;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [11:0] MADDR_RST = 12'h000;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_Q1 = 3'b001,
    ST_Q2 = 3'b010,
    ST_Q3 = 3'b011,
    ST_Q4 = 3'b100
  } mnd_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_MULL = 2'b01,
    OP_MULF = 2'b10,
    OP_NEG = 2'b11
  } mnd_op_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } mnd_flags_t;

  localparam mnd_flags_t FLAGS_RST = 5'h00;

  typedef struct packed {
    logic [15:0] prod;
    logic [7:0] neg;
    mnd_flags_t flags;
  } mnd_alu_t;

endpackage
